// *** rtl/srm_device.sv ***
// Summary of operation
// - I/O supply undervoltage, filtered, drives reset low
// - Filtered external reset low resets same logic
// - Config six bit 3 masks 5V undervoltage
// - 5V undervoltage asserts reset, latches crank flag
// - Release reset after 17 ms once 5V good
// - Reset held at power-on until 5V present
// - Power down asserts reset, everything off
// - Latch mode key edge pulses reset, flags it
// - Long battery overvoltage: reset, regulators off
// - Short battery overvoltage: drivers off, config kept
// - Battery overvoltage flag, cleared by diagnostic read
// - Reset clears config, 5V overvoltage and link fail flags, disables drivers
// - Long undervoltage/external reset also resets low-battery
// - 5V overvoltage disables drivers, sets flag
// - Long battery overvoltage: relay on, regulators off
// - External reset leaves power manager unchanged
// - Software reset command: logic reset, pin idle
// - Link watchdog expiry disables drivers, flags fail
// - Masked undervoltage with output enabled holds data low
// - Host detects long low, disables, polls, re-enables
// - Host polls crank flag when masked and output signalling off
// - Latch disable bit low keeps power latch
// - Key input is the deglitched key status
`include "srm_map.svh"
`default_nettype none
module srm_filt #(
    parameter int N = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cond,
    output logic hit
);
    localparam int W = $clog2(N + 1);
    logic [W-1:0] cnt_reg;
    assign hit = (cnt_reg == W'(N));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (!cond) begin
            cnt_reg <= '0;
        end else if (!hit) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule // srm_filt

module srm_device #(
    parameter int UV_REL_CYC = `SRM_CYC(`SRM_UV_REL_US),
    parameter int LATCH_CYC = `SRM_CYC(`SRM_LATCH_US),
    parameter int BOV1_CYC = `SRM_CYC(`SRM_BOV1_US),
    parameter int BOV2_CYC = `SRM_CYC(`SRM_BOV2_US),
    parameter int HOLD_CYC = `SRM_CYC(`SRM_HOLD_US),
    parameter int LINK_WD_CYC = `SRM_CYC(`SRM_LINK_WD_US)
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic KEY_FLT,
    input wire logic VDDIO_LOW,
    input wire logic VDD5_LOW,
    input wire logic VDD5_GOOD,
    input wire logic SUPPLY5_OV_FLAG,
    input wire logic BATTERY_OV_FLAG,
    srm_if.dev LINK,
    output logic MRD_ON,
    output logic REGS_ON,
    output logic DRV_EN,
    output logic LB_DRV_EN,
    output logic LOGIC_RST,
    output logic LB_RST,
    output logic [7:0] CFG_OUT,
    output logic [7:0] LB_CFG_OUT
);
    localparam int FILT_CYC = `SRM_CYC(`SRM_FILT_US);
    localparam int LPW = $clog2(LATCH_CYC + 1);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [6:0] sy1_reg;
    logic [6:0] sy2_reg;
    wire [6:0] pins = {LINK.rst_line, BATTERY_OV_FLAG, SUPPLY5_OV_FLAG, VDD5_GOOD, VDD5_LOW, VDDIO_LOW, KEY_FLT};
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sy1_reg <= `SRM_SYNC_RST;
            sy2_reg <= `SRM_SYNC_RST;
        end else begin
            sy1_reg <= pins;
            sy2_reg <= sy1_reg;
        end
    end
    wire key = sy2_reg[0];
    wire io_low = sy2_reg[1];
    wire v5_low = sy2_reg[2];
    wire v5_good = sy2_reg[3];
    wire v5_ov = sy2_reg[4];
    wire battery_ov_flag = sy2_reg[5];
    wire rst_pin = sy2_reg[6];
    // ----------------------------------------
    // State
    // ----------------------------------------
    srm_pkg::srm_pm_e pm_reg;
    srm_pkg::srm_pm_e pm_next;
    srm_pkg::srm_byte_t cfg_reg;
    srm_pkg::srm_byte_t lbcfg_reg;
    srm_pkg::srm_byte_t ctrl_reg;
    srm_pkg::srm_byte_t ctrl_next;
    srm_pkg::srm_byte_t cfg6_reg;
    srm_pkg::srm_byte_t diag_reg;
    srm_pkg::srm_byte_t diag_next;
    srm_pkg::srm_byte_t flag_set;
    srm_pkg::srm_byte_t rd_mux;
    logic [LPW-1:0] lp_reg;
    logic hold_reg;
    logic drv_reg;
    logic drv_d1_reg;
    logic drv_d2_reg;
    logic key_d_reg;
    logic wd_d_reg;
    logic sdo_lat_reg;
    logic io_uv_f;
    logic uv_f;
    logic ext_f;
    logic bov1_f;
    logic bov2_f;
    logic long_f;
    logic rel_f;
    logic wd_f;
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire wr = LINK.link_req & LINK.link_wr;
    wire rd = LINK.link_req & !LINK.link_wr;
    wire wr_ctrl = wr & (LINK.link_addr == `SRM_A_CTRL);
    wire diag_rd = rd & (LINK.link_addr == `SRM_A_DIAG);
    wire sw_rst = wr_ctrl & LINK.link_wdata[`SRM_C_SWRST];
    wire uv_mask = cfg6_reg[`SRM_G_MASK];
    wire sdo_en = cfg6_reg[`SRM_G_SDOEN];
    wire uv_src = uv_f & !uv_mask;
    wire pld = ctrl_reg[`SRM_C_PLD];
    wire pwr_en = !pld | key;
    wire pd = (pm_reg == srm_pkg::PM_OFF);
    wire key_rise = key & !key_d_reg;
    wire lp_start = !pd & !pld & cfg6_reg[`SRM_G_LREN] & key_rise;
    wire lp_active = (lp_reg != '0);
    wire drv_next = pd | hold_reg | io_uv_f | lp_active | bov2_f;
    wire ext_low = !rst_pin & !drv_reg & !drv_d1_reg & !drv_d2_reg;
    wire logic_rst = drv_reg | ext_f | sw_rst;
    wire lb_off = pd | lp_active | bov2_f | long_f | sw_rst | bov1_f;
    wire lb_rst = lb_off & !(bov1_f & !bov2_f);
    wire wd_rise = wd_f & !wd_d_reg;
    wire iface_rst = logic_rst | v5_ov | wd_rise | bov1_f;
    wire sdo_set = uv_f & uv_mask & sdo_en;
    wire sdo_lat_next = sdo_set | (sdo_lat_reg & sdo_en);
    assign rd_mux = (LINK.link_addr == `SRM_A_CFG) ? cfg_reg :
                    (LINK.link_addr == `SRM_A_LBCFG) ? lbcfg_reg :
                    (LINK.link_addr == `SRM_A_CTRL) ? ctrl_reg :
                    (LINK.link_addr == `SRM_A_CFG6) ? cfg6_reg :
                    (LINK.link_addr == `SRM_A_DIAG) ? diag_reg : 8'h00;
    // ----------------------------------------
    // Filters and timers
    // ----------------------------------------
    srm_filt #(.N(FILT_CYC)) u_io (.clk(CORE_CLK), .rst(RST), .cond(io_low), .hit(io_uv_f));
    srm_filt #(.N(FILT_CYC)) u_uv (.clk(CORE_CLK), .rst(RST), .cond(v5_low), .hit(uv_f));
    srm_filt #(.N(FILT_CYC)) u_ext (.clk(CORE_CLK), .rst(RST), .cond(ext_low), .hit(ext_f));
    srm_filt #(.N(BOV1_CYC)) u_bov1 (.clk(CORE_CLK), .rst(RST), .cond(battery_ov_flag), .hit(bov1_f));
    srm_filt #(.N(BOV2_CYC)) u_bov2 (.clk(CORE_CLK), .rst(RST), .cond(battery_ov_flag), .hit(bov2_f));
    srm_filt #(.N(HOLD_CYC)) u_hold (
        .clk(CORE_CLK), .rst(RST), .cond(uv_src | ext_f), .hit(long_f));
    srm_filt #(.N(UV_REL_CYC)) u_rel (
        .clk(CORE_CLK), .rst(RST), .cond(hold_reg & v5_good & !uv_src & !pd), .hit(rel_f));
    srm_filt #(.N(LINK_WD_CYC)) u_wd (
        .clk(CORE_CLK), .rst(RST), .cond(!LINK.link_req & !logic_rst), .hit(wd_f));
    // ----------------------------------------
    // Power manager
    // ----------------------------------------
    always_comb begin
        pm_next = pm_reg;
        unique case (pm_reg)
            srm_pkg::PM_OFF: begin
                if (pwr_en) begin
                    pm_next = srm_pkg::PM_ON;
                end
            end
            srm_pkg::PM_ON: begin
                if (!pwr_en) begin
                    pm_next = srm_pkg::PM_OFF;
                end else if (bov2_f) begin
                    pm_next = srm_pkg::PM_OVR;
                end
            end
            srm_pkg::PM_OVR: begin
                if (!pwr_en) begin
                    pm_next = srm_pkg::PM_OFF;
                end else if (!battery_ov_flag) begin
                    pm_next = srm_pkg::PM_ON;
                end
            end
        endcase
    end
    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = LINK.link_wdata & ~`SRM_C_SWRST_M;
        end
        if (iface_rst) begin
            ctrl_next[`SRM_C_OUTDIS] = 1'b1;
        end
        if (lb_off) begin
            ctrl_next[`SRM_C_LBDIS] = 1'b1;
        end
    end
    always_comb begin
        flag_set = 8'h00;
        flag_set[`SRM_D_CRK] = uv_f;
        flag_set[`SRM_D_LUV] = uv_src & long_f;
        flag_set[`SRM_D_LRST] = lp_start;
        flag_set[`SRM_D_BOV] = bov1_f;
        flag_set[`SRM_D_S5OV] = v5_ov;
        flag_set[`SRM_D_LFAIL] = wd_rise;
        // Set wins over read clear; reset-unit flags survive logic reset
        diag_next = flag_set | (diag_reg & ~{8{diag_rd}} & (logic_rst ? `SRM_D_KEEP : 8'hFF));
    end
    // ----------------------------------------
    // Flops
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pm_reg <= srm_pkg::PM_OFF;
            hold_reg <= 1'b1;
            drv_reg <= 1'b1;
            drv_d1_reg <= 1'b1;
            drv_d2_reg <= 1'b1;
            key_d_reg <= 1'b0;
            wd_d_reg <= 1'b0;
            lp_reg <= '0;
        end else begin
            pm_reg <= pm_next;
            hold_reg <= uv_src | pd | (hold_reg & !rel_f);
            drv_reg <= drv_next;
            drv_d1_reg <= drv_reg;
            drv_d2_reg <= drv_d1_reg;
            key_d_reg <= key;
            wd_d_reg <= wd_f;
            lp_reg <= lp_start ? LPW'(LATCH_CYC) : (lp_active ? lp_reg - 1'b1 : lp_reg);
        end
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cfg_reg <= 8'h00;
            lbcfg_reg <= 8'h00;
            ctrl_reg <= `SRM_CTRL_RST;
            cfg6_reg <= 8'h00;
            diag_reg <= 8'h00;
        end else begin
            cfg_reg <= logic_rst ? 8'h00 : (wr & (LINK.link_addr == `SRM_A_CFG)) ?
                LINK.link_wdata : cfg_reg;
            lbcfg_reg <= lb_rst ? 8'h00 : (wr & (LINK.link_addr == `SRM_A_LBCFG)) ?
                LINK.link_wdata : lbcfg_reg;
            ctrl_reg <= ctrl_next;
            cfg6_reg <= (wr & (LINK.link_addr == `SRM_A_CFG6)) ? LINK.link_wdata : cfg6_reg;
            diag_reg <= diag_next;
        end
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            MRD_ON <= 1'b0;
            REGS_ON <= 1'b0;
            DRV_EN <= 1'b0;
            LB_DRV_EN <= 1'b0;
            LOGIC_RST <= 1'b1;
            LB_RST <= 1'b1;
            sdo_lat_reg <= 1'b0;
            LINK.sdo <= 1'b1;
            LINK.link_rdata <= 8'h00;
            LINK.link_rvalid <= 1'b0;
        end else begin
            MRD_ON <= (pm_next != srm_pkg::PM_OFF);
            REGS_ON <= (pm_next == srm_pkg::PM_ON);
            DRV_EN <= !ctrl_next[`SRM_C_OUTDIS];
            LB_DRV_EN <= !ctrl_next[`SRM_C_LBDIS];
            LOGIC_RST <= logic_rst;
            LB_RST <= lb_rst;
            sdo_lat_reg <= sdo_lat_next;
            LINK.sdo <= !sdo_lat_next;
            LINK.link_rdata <= rd ? rd_mux : LINK.link_rdata;
            LINK.link_rvalid <= rd;
        end
    end
    assign CFG_OUT = cfg_reg;
    assign LB_CFG_OUT = lbcfg_reg;
    assign LINK.rst_dev_o = 1'b0;
    assign LINK.rst_dev_oe = drv_reg;
endmodule // srm_device
`default_nettype wire

// *** rtl/srm_map.svh ***
`ifndef SRM_MAP_SVH
`define SRM_MAP_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SRM_CLK_NS 8
`define SRM_CYC(us) (((us) * 1000 + `SRM_CLK_NS - 1) / `SRM_CLK_NS)
`define SRM_FILT_US 10
`define SRM_UV_REL_US 17000
`define SRM_LATCH_US 1400
`define SRM_BOV1_US 63
`define SRM_BOV2_US 11000
`define SRM_HOLD_US 5000
`define SRM_LINK_WD_US 1000
`define SRM_FRAME_US 2
`define SRM_POLL_US 100
// ----------------------------------------
// Register indices
// ----------------------------------------
`define SRM_A_CFG 4'h0
`define SRM_A_LBCFG 4'h1
`define SRM_A_CTRL 4'h2
`define SRM_A_CFG6 4'h6
`define SRM_A_DIAG 4'h8
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SRM_C_OUTDIS 0
`define SRM_C_LBDIS 1
`define SRM_C_PLD 2
`define SRM_C_SWRST_M 8'h80
`define SRM_C_SWRST 7
`define SRM_CTRL_RST 8'h07
`define SRM_G_LREN 1
`define SRM_G_SDOEN 2
`define SRM_G_MASK 3
`define SRM_G_SDOEN_M 8'h04
`define SRM_D_CRK 0
`define SRM_D_LUV 1
`define SRM_D_LRST 2
`define SRM_D_BOV 3
`define SRM_D_S5OV 4
`define SRM_D_LFAIL 5
`define SRM_D_KEEP 8'h0F
`define SRM_SYNC_RST 7'h40
`endif

// *** rtl/srm_pkg.sv ***
`default_nettype none
package srm_pkg;
    typedef logic [7:0] srm_byte_t;
    typedef logic [3:0] srm_addr_t;
    typedef enum {PM_OFF, PM_ON, PM_OVR} srm_pm_e;
    typedef enum {H_IDLE, H_DIS, H_POLL, H_WAIT, H_EN} srm_host_e;
endpackage
`default_nettype wire

// *** rtl/srm_if.sv ***
`default_nettype none
interface srm_if;
    logic link_req;
    logic link_wr;
    srm_pkg::srm_addr_t link_addr;
    srm_pkg::srm_byte_t link_wdata;
    srm_pkg::srm_byte_t link_rdata;
    logic link_rvalid;
    logic sdo;
    logic rst_dev_o;
    logic rst_dev_oe;
    logic rst_host_o;
    logic rst_host_oe;
    logic rst_line;
    // Open-drain reset line with pull-up
    assign rst_line = (rst_dev_oe ? rst_dev_o : 1'b1) & (rst_host_oe ? rst_host_o : 1'b1);
    modport dev (
        input link_req, link_wr, link_addr, link_wdata, rst_line,
        output link_rdata, link_rvalid, sdo, rst_dev_o, rst_dev_oe
    );
    modport host (
        output link_req, link_wr, link_addr, link_wdata, rst_host_o, rst_host_oe,
        input link_rdata, link_rvalid, sdo, rst_line
    );
endinterface
`default_nettype wire

// *** rtl/srm_host.sv ***
`include "srm_map.svh"
`default_nettype none
module srm_host #(
    parameter int POLL_CYC = `SRM_CYC(`SRM_POLL_US)
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    srm_if.host LINK,
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [3:0] CMD_ADDR,
    input wire logic [7:0] CMD_WDATA,
    output logic CMD_BUSY,
    output logic [7:0] CMD_RDATA,
    output logic CMD_RVALID,
    input wire logic RST_REQ,
    output logic RST_SEEN,
    output logic UV_SEEN
);
    localparam int FRAME_CYC = `SRM_CYC(`SRM_FRAME_US);
    localparam int FW = $clog2(FRAME_CYC + 1);
    localparam int PW = $clog2(POLL_CYC + 1);
    // ----------------------------------------
    // State
    // ----------------------------------------
    srm_pkg::srm_host_e st_reg;
    srm_pkg::srm_host_e st_next;
    srm_pkg::srm_byte_t sh_reg;
    srm_pkg::srm_byte_t a_wdata;
    srm_pkg::srm_addr_t a_addr;
    logic [1:0] h1_reg;
    logic [1:0] h2_reg;
    logic [FW-1:0] lo_reg;
    logic [PW-1:0] pc_reg;
    logic a_req;
    logic a_wr;
    logic usr_rd_reg;
    logic diag_rd_reg;
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire sdo_s = h2_reg[0];
    wire mode2 = sh_reg[`SRM_G_MASK] & !sh_reg[`SRM_G_SDOEN];
    wire mode3 = sh_reg[`SRM_G_MASK] & sh_reg[`SRM_G_SDOEN];
    wire sdo_uv = (lo_reg == FW'(FRAME_CYC));
    wire poll_due = (pc_reg == PW'(POLL_CYC));
    wire crk = LINK.link_rdata[`SRM_D_CRK];
    wire diag_resp = LINK.link_rvalid & diag_rd_reg;
    wire user_ok = (st_reg == srm_pkg::H_IDLE) & (st_next == srm_pkg::H_IDLE);
    wire u_req = user_ok & (CMD_WR | CMD_RD);
    assign LINK.link_req = a_req | u_req;
    assign LINK.link_wr = a_req ? a_wr : CMD_WR;
    assign LINK.link_addr = a_req ? a_addr : CMD_ADDR;
    assign LINK.link_wdata = a_req ? a_wdata : CMD_WDATA;
    assign LINK.rst_host_o = 1'b0;
    assign LINK.rst_host_oe = RST_REQ;
    assign CMD_BUSY = !user_ok;
    assign CMD_RDATA = LINK.link_rdata;
    assign CMD_RVALID = LINK.link_rvalid & usr_rd_reg;
    // ----------------------------------------
    // Undervoltage handling sequence
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        a_req = 1'b0;
        a_wr = 1'b0;
        a_addr = `SRM_A_DIAG;
        a_wdata = sh_reg;
        unique case (st_reg)
            srm_pkg::H_IDLE: begin
                if (mode3 & sdo_uv) begin
                    st_next = srm_pkg::H_DIS;
                end else if (mode2 & poll_due) begin
                    st_next = srm_pkg::H_POLL;
                end
            end
            srm_pkg::H_DIS: begin
                a_req = 1'b1;
                a_wr = 1'b1;
                a_addr = `SRM_A_CFG6;
                a_wdata = sh_reg & ~`SRM_G_SDOEN_M;
                st_next = srm_pkg::H_POLL;
            end
            srm_pkg::H_POLL: begin
                a_req = 1'b1;
                st_next = srm_pkg::H_WAIT;
            end
            srm_pkg::H_WAIT: begin
                if (LINK.link_rvalid) begin
                    // In mode3 keep polling until the crank flag has healed; in mode2 return to idle after one read
                    st_next = !mode3 ? srm_pkg::H_IDLE : crk ? srm_pkg::H_POLL : srm_pkg::H_EN;
                end
            end
            srm_pkg::H_EN: begin
                a_req = 1'b1;
                a_wr = 1'b1;
                a_addr = `SRM_A_CFG6;
                st_next = srm_pkg::H_IDLE;
            end
        endcase
    end
    // ----------------------------------------
    // Flops
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            h1_reg <= 2'h3;
            h2_reg <= 2'h3;
            lo_reg <= '0;
            pc_reg <= '0;
            st_reg <= srm_pkg::H_IDLE;
        end else begin
            h1_reg <= {LINK.rst_line, LINK.sdo};
            h2_reg <= h1_reg;
            lo_reg <= sdo_s ? '0 : (sdo_uv ? lo_reg : lo_reg + 1'b1);
            pc_reg <= (!mode2 | (st_reg != srm_pkg::H_IDLE)) ? '0 :
                (poll_due ? pc_reg : pc_reg + 1'b1);
            st_reg <= st_next;
        end
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sh_reg <= 8'h00;
            usr_rd_reg <= 1'b0;
            diag_rd_reg <= 1'b0;
            RST_SEEN <= 1'b0;
            UV_SEEN <= 1'b0;
        end else begin
            sh_reg <= (u_req & CMD_WR & (CMD_ADDR == `SRM_A_CFG6)) ? CMD_WDATA : sh_reg;
            usr_rd_reg <= u_req & CMD_RD;
            diag_rd_reg <= LINK.link_req & !LINK.link_wr & (LINK.link_addr == `SRM_A_DIAG);
            RST_SEEN <= !h2_reg[1];
            UV_SEEN <= (mode3 & sdo_uv) | (diag_resp ? crk : UV_SEEN);
        end
    end
endmodule // srm_host
`default_nettype wire

// *** sim/srm_asserts.sv ***
`include "srm_map.svh"
`default_nettype none
module srm_asserts (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic link_req,
    input wire logic link_wr,
    input wire srm_pkg::srm_addr_t link_addr,
    input wire srm_pkg::srm_byte_t link_wdata,
    input wire srm_pkg::srm_byte_t link_rdata,
    input wire logic link_rvalid,
    input wire logic sdo,
    input wire logic rst_dev_oe,
    input wire logic rst_line
);
    // ----------------------------------------
    // Decode of link traffic
    // ----------------------------------------
    wire rd_hit = link_req && !link_wr;
    wire sdo_off = link_req && link_wr && link_addr == `SRM_A_CFG6 && !link_wdata[`SRM_G_SDOEN];
    wire mapped = link_addr inside {`SRM_A_CFG, `SRM_A_LBCFG, `SRM_A_CTRL, `SRM_A_CFG6, `SRM_A_DIAG};
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence read_req;
        rd_hit;
    endsequence
    sequence uv_output_off;
        sdo_off;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_read_answered: assert property (read_req |=> link_rvalid)
        else $error("read not answered next cycle");
    a_rvalid_caused: assert property (link_rvalid |-> $past(rd_hit))
        else $error("read answer without request");
    a_unmapped_zero: assert property (read_req ##0 !mapped |=> link_rdata == 8'h00)
        else $error("unmapped index read not zero");
    a_swrst_not_kept: assert property (read_req ##0 link_addr == `SRM_A_CTRL |=> !link_rdata[7])
        else $error("software reset bit reads back set");
    a_rdata_holds: assert property ($changed(link_rdata) |-> link_rvalid)
        else $error("read data changed without answer");
    a_dev_pulls_line: assert property (rst_dev_oe |-> !rst_line)
        else $error("reset line high while device drives it");
    a_sdo_released: assert property (uv_output_off |-> ##[1:3] sdo)
        else $error("data output stays low after disable");
    a_sdo_latched: assert property (!sdo && !sdo_off && !$past(sdo_off) |=> !sdo)
        else $error("data output low released too early");
endmodule // srm_asserts
`default_nettype wire

// *** sim/tb.sv ***
`include "srm_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic key = 1'b0, io_low = 1'b0, v5_low = 1'b0, v5_good = 1'b0, v5_ov = 1'b0, battery_ov_flag = 1'b0;
    logic cmd_wr = 1'b0, cmd_rd = 1'b0, rst_req = 1'b0;
    logic [3:0] cmd_addr = 4'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic mrd_on, regs_on, drv_en, logic_rst, cmd_busy, cmd_rvalid, rst_seen, uv_seen;
    logic lb_drv_en, lb_rst;
    logic [7:0] cfg_out, lb_cfg_out, cmd_rdata, d;
    logic [15:0] note;
    logic [15:0] note_q[$];
    int err_count = 0;
    int comparisons = 0;
    int n;
    srm_if u_srm_if ();
    srm_device #(.UV_REL_CYC(50), .LATCH_CYC(20), .BOV1_CYC(10), .BOV2_CYC(40), .HOLD_CYC(30),
        .LINK_WD_CYC(200)) u_srm_device (.CORE_CLK(core_clk), .RST(rst), .KEY_FLT(key),
        .VDDIO_LOW(io_low), .VDD5_LOW(v5_low), .VDD5_GOOD(v5_good), .SUPPLY5_OV_FLAG(v5_ov),
        .BATTERY_OV_FLAG(battery_ov_flag), .LINK(u_srm_if.dev), .MRD_ON(mrd_on), .REGS_ON(regs_on), .DRV_EN(drv_en),
        .LB_DRV_EN(lb_drv_en), .LOGIC_RST(logic_rst), .LB_RST(lb_rst), .CFG_OUT(cfg_out),
        .LB_CFG_OUT(lb_cfg_out));
    srm_host #(.POLL_CYC(20)) u_srm_host (.CORE_CLK(core_clk), .RST(rst), .LINK(u_srm_if.host),
        .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
        .CMD_BUSY(cmd_busy), .CMD_RDATA(cmd_rdata), .CMD_RVALID(cmd_rvalid), .RST_REQ(rst_req),
        .RST_SEEN(rst_seen), .UV_SEEN(uv_seen));
    srm_asserts u_srm_asserts (.CORE_CLK(core_clk), .RST(rst), .link_req(u_srm_if.link_req),
        .link_wr(u_srm_if.link_wr), .link_addr(u_srm_if.link_addr),
        .link_wdata(u_srm_if.link_wdata), .link_rdata(u_srm_if.link_rdata),
        .link_rvalid(u_srm_if.link_rvalid), .sdo(u_srm_if.sdo),
        .rst_dev_oe(u_srm_if.rst_dev_oe), .rst_line(u_srm_if.rst_line));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic chb(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        cmd_wr <= 1'b1;
        cmd_addr <= a;
        cmd_wdata <= v;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge core_clk);
        note_q.push_back({e, m});
        cmd_rd <= 1'b1;
        cmd_addr <= a;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
    endtask
    // Release waits include the full delay after the cause has gone
    task automatic wait_line(input int lim);
        n = 0;
        while (u_srm_if.rst_line !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chb(u_srm_if.rst_line, 1'b1);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(negedge core_clk) begin
        if (cmd_rvalid === 1'b1) begin
            if (note_q.size() == 0) begin
                chb(cmd_rvalid, 1'b0);
            end else begin
                note = note_q.pop_front();
                chk(cmd_rdata & note[7:0], note[15:8] & note[7:0]);
            end
        end
    end
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(24306));
        cyc(10);
        rst <= 1'b0;
        cyc(2);
        key <= 1'b1;
        cyc(100);
        chb(u_srm_if.rst_line, 1'b0);
        v5_good <= 1'b1;
        wait_line(400);
        chb(n >= 50, 1'b1);
        d = 8'($urandom());
        wr(`SRM_A_CFG, d);
        wr(`SRM_A_LBCFG, d);
        rd(`SRM_A_CFG, d, 8'hFF);
        wr(`SRM_A_CTRL, 8'h04);
        rd(4'hF, 8'h00, 8'hFF);
        chb(drv_en, 1'b1);
        chk(lb_cfg_out, d);
        wr(`SRM_A_CTRL, 8'h84);
        cyc(3);
        chb(u_srm_if.rst_line, 1'b1);
        chb(regs_on, 1'b1);
        rd(`SRM_A_CFG, 8'h00, 8'hFF);
        chk(lb_cfg_out, 8'h00);
        rst_req <= 1'b1;
        cyc(500);
        rst_req <= 1'b0;
        cyc(5);
        chb(logic_rst, 1'b0);
        rst_req <= 1'b1;
        cyc(1400);
        chb(rst_seen, 1'b1);
        chb(logic_rst, 1'b1);
        chb(mrd_on, 1'b1);
        chb(lb_rst, 1'b1);
        chb(regs_on, 1'b1);
        rst_req <= 1'b0;
        wait_line(400);
        io_low <= 1'b1;
        cyc(100);
        io_low <= 1'b0;
        cyc(5);
        chb(u_srm_if.rst_line, 1'b1);
        wr(`SRM_A_CFG, d);
        io_low <= 1'b1;
        cyc(1300);
        chb(u_srm_if.rst_line, 1'b0);
        chb(drv_en, 1'b0);
        chk(cfg_out, 8'h00);
        io_low <= 1'b0;
        wait_line(400);
        v5_low <= 1'b1;
        v5_good <= 1'b0;
        cyc(1300);
        chb(u_srm_if.rst_line, 1'b0);
        v5_low <= 1'b0;
        v5_good <= 1'b1;
        wait_line(400);
        rd(`SRM_A_DIAG, 8'h01, 8'h01);
        rd(`SRM_A_DIAG, 8'h00, 8'h01);
        wr(`SRM_A_CFG6, 8'h0C);
        v5_low <= 1'b1;
        v5_good <= 1'b0;
        cyc(1350);
        chb(u_srm_if.rst_line, 1'b1);
        chb(u_srm_if.sdo, 1'b0);
        cyc(400);
        chb(uv_seen, 1'b1);
        v5_low <= 1'b0;
        v5_good <= 1'b1;
        n = 0;
        while ((uv_seen !== 1'b0 || cmd_busy !== 1'b0) && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chb(uv_seen, 1'b0);
        cyc(5);
        chb(u_srm_if.sdo, 1'b1);
        wr(`SRM_A_CFG6, 8'h08);
        v5_low <= 1'b1;
        v5_good <= 1'b0;
        cyc(1300);
        chb(uv_seen, 1'b1);
        v5_low <= 1'b0;
        v5_good <= 1'b1;
        cyc(100);
        chb(uv_seen, 1'b0);
        // Writes are dropped during a poll
        wait (cmd_busy === 1'b1);
        wait (cmd_busy === 1'b0);
        wr(`SRM_A_CFG6, 8'h00);
        d = 8'($urandom());
        wr(`SRM_A_CFG, d);
        wr(`SRM_A_CTRL, 8'h04);
        battery_ov_flag <= 1'b1;
        cyc(30);
        battery_ov_flag <= 1'b0;
        cyc(5);
        chb(drv_en, 1'b0);
        chb(u_srm_if.rst_line, 1'b1);
        chk(cfg_out, d);
        chb(lb_drv_en, 1'b0);
        rd(`SRM_A_DIAG, 8'h08, 8'h08);
        battery_ov_flag <= 1'b1;
        cyc(60);
        chb(u_srm_if.rst_line, 1'b0);
        chb(regs_on, 1'b0);
        chb(mrd_on, 1'b1);
        battery_ov_flag <= 1'b0;
        wait_line(400);
        wr(`SRM_A_CTRL, 8'h04);
        v5_ov <= 1'b1;
        cyc(5);
        v5_ov <= 1'b0;
        cyc(4);
        chb(drv_en, 1'b0);
        chb(u_srm_if.rst_line, 1'b1);
        rd(`SRM_A_DIAG, 8'h10, 8'h10);
        wr(`SRM_A_CFG6, 8'h02);
        wr(`SRM_A_CTRL, 8'h00);
        key <= 1'b0;
        cyc(10);
        chb(mrd_on, 1'b1);
        key <= 1'b1;
        cyc(8);
        chb(u_srm_if.rst_line, 1'b0);
        chb(regs_on, 1'b1);
        wait_line(100);
        rd(`SRM_A_DIAG, 8'h04, 8'h04);
        wr(`SRM_A_CTRL, 8'h04);
        key <= 1'b0;
        cyc(10);
        chb(u_srm_if.rst_line, 1'b0);
        chb(mrd_on, 1'b0);
        chb(regs_on, 1'b0);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
